/* File: ext_memory_bus_control.sv */
// Behaviour
// RULE_01 - Twenty-seven pins serve the bus, shared with I/O on four port groups.
// RULE_02 - Three groups carry address/data lines; the fourth carries the strobes.
// RULE_03 - The bus is always sixteen bits wide; no byte-wide bus exists.
// RULE_04 - Four program memory modes; pin function follows mode and disable bit.
// RULE_05 - Fully external mode: bus always active, pins never I/O.
// RULE_06 - Fully internal mode: bus inactive, pins only I/O.
// RULE_07 - Fully internal mode: control register ignores writes, reads zero.
// RULE_08 - Mixed modes: any external fetch or table access switches pins to bus.
// RULE_09 - Mixed modes, internal only: disable 0 keeps bus, 1 gives I/O.
// RULE_10 - Word write mode drives both buffered bytes, high strobe on odd byte.
// RULE_11 - Byte select copies latch to both halves, high strobe with byte enable; the UB strobe never reaches a pin, so an odd byte goes out with no enable.
// RULE_12 - Wait field adds 0 to 3 cycles to table cycles, 11 means zero.
// RULE_13 - Byte write copies latch to both halves, strobe chosen by pointer LSB.
// RULE_14 - Disable set from external code waits for a branch into internal memory.
// RULE_15 - Idle bus: data lines released, strobes high, latch and byte address low.
//
// The implementer's own choices: the placing of the registers and strobed register access.
module ext_memory_bus_control (
  input  wire logic                               clk,
  input  wire logic                               srst,
  // Register port
  input  wire logic [3:0]                         reg_addr,
  input  wire logic [7:0]                         reg_wdata,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  output logic      [7:0]                         reg_rdata,
  // Core side
  input  wire ext_memory_bus_pkg::prog_mode_t     prog_mode,
  input  wire logic                               exec_external,
  input  wire logic                               ext_req,
  input  wire logic                               ext_is_fetch,
  input  wire logic                               ext_is_write,
  input  wire logic [20:0]                        table_pointer,
  input  wire logic [7:0]                         table_latch,
  output logic                                    ext_busy,
  output logic                                    ext_done,
  output logic      [15:0]                        ext_rdata,
  // Port function side
  input  wire logic [26:0]                        port_out,
  input  wire logic [26:0]                        port_oe_n,
  output logic                                    pins_are_bus,
  // Pads
  input  wire logic [26:0]                        pin_in,
  output logic      [26:0]                        pin_out,
  output logic      [26:0]                        pin_oe_n
);

  bus_req_if req ();

  logic [7:0]  memory_bus_control_reg;
  logic        disable_eff_reg;
  logic [7:0]  hold_latch_reg;
  logic [15:0] ad_sync1_reg;
  logic [15:0] ad_sync2_reg;
  logic        bus_active;
  logic        internal_mode;
  logic        mixed_mode;
  logic [1:0]  wmode;
  logic [15:0] ad_out;
  logic [15:0] ad_oe_n;
  logic [3:0]  ahi_out;
  logic [7:0]  ctrl_out;
  logic [26:0] bus_out;
  logic [26:0] bus_oe_n;
  logic [15:0] wr_data;
  logic [7:0]  wr_strobe;

  assign internal_mode = (prog_mode == ext_memory_bus_pkg::MODE_MICROCONTROLLER);
  assign mixed_mode    = (prog_mode == ext_memory_bus_pkg::MODE_BOOT_BLOCK) ||
                         (prog_mode == ext_memory_bus_pkg::MODE_EXTENDED);
  assign wmode         = memory_bus_control_reg[ext_memory_bus_pkg::WMODE_LSB +: 2];

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Writes are dropped and contents held at zero in the internal mode
  always_ff @(posedge clk)
  begin
    if (srst || internal_mode)
      memory_bus_control_reg <= ext_memory_bus_pkg::MEMORY_BUS_CONTROL_RST; // see RULE_07
    else if (reg_wr && reg_addr == ext_memory_bus_pkg::REG_MEMORY_BUS_CONTROL)
      memory_bus_control_reg <= reg_wdata & ext_memory_bus_pkg::CONTROL_WMASK;
  end

  // Read data valid in the cycle after the strobe only
  always_ff @(posedge clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_rd && reg_addr == ext_memory_bus_pkg::REG_MEMORY_BUS_CONTROL)
      reg_rdata <= internal_mode ? 8'h00 : memory_bus_control_reg; // see RULE_07
    else if (reg_rd && reg_addr == ext_memory_bus_pkg::REG_BUS_STATUS)
      reg_rdata <= {5'h00, disable_eff_reg, req.busy, bus_active};
    else
      reg_rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Effective disable bit
  // ----------------------------------------------------------------
  // Setting takes hold only once execution is back in internal memory,
  // so code running from the bus never pulls the pins from under itself
  always_ff @(posedge clk)
  begin
    if (srst)
      disable_eff_reg <= 1'b0;
    else if (!memory_bus_control_reg[ext_memory_bus_pkg::BIT_EXT_BUS_DISABLE])
      disable_eff_reg <= 1'b0;
    else if (!exec_external)
      disable_eff_reg <= 1'b1; // see RULE_14
  end

  // ----------------------------------------------------------------
  // Pin function decision
  // ----------------------------------------------------------------
  always_comb
  begin
    bus_active = 1'b0;
    unique case (prog_mode)
      ext_memory_bus_pkg::MODE_MICROPROCESSOR:  bus_active = 1'b1; // see RULE_05
      ext_memory_bus_pkg::MODE_MICROCONTROLLER: bus_active = 1'b0; // see RULE_06
      ext_memory_bus_pkg::MODE_BOOT_BLOCK,
      ext_memory_bus_pkg::MODE_EXTENDED:
        // External access always wins; otherwise the disable bit decides
        bus_active = ext_req || req.busy || exec_external || !disable_eff_reg; // see RULE_08
    endcase
  end
  assign pins_are_bus = bus_active && (mixed_mode || !internal_mode); // see RULE_04
  // Mixed-mode internal-only pin ownership follows disable_eff_reg above // see RULE_09

  // ----------------------------------------------------------------
  // Word-write holding latch for the even byte
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
      hold_latch_reg <= 8'h00;
    else if (ext_req && ext_is_write && !req.busy && wmode[1] && !table_pointer[0])
      hold_latch_reg <= table_latch;
  end

  // ----------------------------------------------------------------
  // Table-write data and strobe selection
  // ----------------------------------------------------------------
  always_comb
  begin
    wr_data   = {table_latch, table_latch};
    wr_strobe = ext_memory_bus_pkg::CTRL_IDLE;
    wr_strobe[ext_memory_bus_pkg::CT_BA0] = table_pointer[0];
    if (wmode[1])
    begin
      // Even byte only fills the latch; odd byte writes the pair
      if (table_pointer[0])
      begin
        wr_data = {table_latch, hold_latch_reg}; // see RULE_10
        wr_strobe[ext_memory_bus_pkg::CT_WRH] = 1'b0;
        wr_strobe[ext_memory_bus_pkg::CT_UB]  = 1'b0;
        wr_strobe[ext_memory_bus_pkg::CT_LB]  = 1'b0;
      end
      else
      begin
        wr_strobe = ext_memory_bus_pkg::CTRL_IDLE;
      end
    end
    else if (wmode == ext_memory_bus_pkg::WMODE_BYTE_SELECT)
    begin
      wr_strobe[ext_memory_bus_pkg::CT_WRH] = 1'b0; // see RULE_11
      if (table_pointer[0])
        wr_strobe[ext_memory_bus_pkg::CT_UB] = 1'b0;
      else
        wr_strobe[ext_memory_bus_pkg::CT_LB] = 1'b0;
    end
    else
    begin
      if (table_pointer[0])
        wr_strobe[ext_memory_bus_pkg::CT_WRH] = 1'b0; // see RULE_13
      else
        wr_strobe[ext_memory_bus_pkg::CT_WRL] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Request to the cycle engine
  // ----------------------------------------------------------------
  // Field 11 means no wait, so the count is the inverted field
  assign req.start      = ext_req && !req.busy && !internal_mode;
  assign req.is_write   = ext_is_write;
  assign req.is_fetch   = ext_is_fetch;
  assign req.addr       = table_pointer[20:1];
  assign req.wait_count = ~memory_bus_control_reg[ext_memory_bus_pkg::WAIT_LSB +: 2]; // see RULE_12
  assign req.wdata      = wr_data; // see RULE_03
  assign req.wstrobe    = wr_strobe;

  assign ext_busy  = req.busy;
  assign ext_done  = req.done;
  assign ext_rdata = req.rdata;

  // Pad data passes two flops before the engine samples it
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ad_sync1_reg <= 16'h0000;
      ad_sync2_reg <= 16'h0000;
    end
    else
    begin
      ad_sync1_reg <= pin_in[15:0];
      ad_sync2_reg <= ad_sync1_reg;
    end
  end

  bus_cycle_engine u_engine (
    .clk        (clk),
    .srst       (srst),
    .req        (req.slave),
    .bus_active (pins_are_bus),
    .ad_in      (ad_sync2_reg),
    .ad_out     (ad_out),
    .ad_oe_n    (ad_oe_n),  // see RULE_15
    .ahi_out    (ahi_out),
    .ctrl_out   (ctrl_out)
  );

  // ----------------------------------------------------------------
  // Pin assembly: 16 address/data, 4 upper address, 7 strobes
  // ----------------------------------------------------------------
  // Strobes drive whenever the bus owns the pins; upper address only inside a cycle
  assign bus_out  = {ctrl_out[ext_memory_bus_pkg::CTRL_WIDTH-2:0], ahi_out, ad_out}; // see RULE_02
  assign bus_oe_n = {7'h00, {4{req.done || !req.busy}}, ad_oe_n}; // see RULE_15

  pin_mux u_pin_mux (
    .pins_are_bus (pins_are_bus), // see RULE_01
    .bus_out      (bus_out),
    .bus_oe_n     (bus_oe_n),
    .port_out     (port_out),
    .port_oe_n    (port_oe_n),
    .pin_out      (pin_out),
    .pin_oe_n     (pin_oe_n)
  );

endmodule : ext_memory_bus_control

/* File: ext_memory_bus_pkg.sv */
package ext_memory_bus_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_MEMORY_BUS_CONTROL = 4'h0;
  localparam logic [3:0] REG_BUS_STATUS         = 4'h1;
  localparam logic [7:0] MEMORY_BUS_CONTROL_RST = 8'h00;

  // Control register fields
  localparam int         BIT_EXT_BUS_DISABLE = 7;
  localparam int         WAIT_LSB            = 4;
  localparam int         WMODE_LSB           = 0;
  localparam logic [7:0] CONTROL_WMASK       = 8'hB3;

  // ----------------------------------------------------------------
  // Pin budget
  // ----------------------------------------------------------------
  localparam int PIN_COUNT  = 27;
  localparam int AD_WIDTH   = 16;
  localparam int AHI_WIDTH  = 4;
  localparam int CTRL_WIDTH = 8;

  // Positions of the strobes in the control port group
  localparam int CT_ALE = 0;
  localparam int CT_OE  = 1;
  localparam int CT_WRL = 2;
  localparam int CT_WRH = 3;
  localparam int CT_BA0 = 4;
  localparam int CT_CE  = 5;
  localparam int CT_LB  = 6;
  localparam int CT_UB  = 7;

  // Idle strobe levels: active-low strobes high, latch and byte address low
  localparam logic [7:0] CTRL_IDLE = 8'hEE;

  // ----------------------------------------------------------------
  // Modes and encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_MICROPROCESSOR = 2'h0,
    MODE_BOOT_BLOCK     = 2'h1,
    MODE_EXTENDED       = 2'h2,
    MODE_MICROCONTROLLER = 2'h3
  } prog_mode_t;

  localparam logic [1:0] WMODE_BYTE_WRITE  = 2'h0;
  localparam logic [1:0] WMODE_BYTE_SELECT = 2'h1;

  // Bus cycle phase lengths in clock cycles
  localparam int ADDR_CYCLES = 1;
  localparam int DATA_CYCLES = 1;
  localparam int MAX_WAIT    = 3;
  // Extra read data cycles so the two-flop pad path shows the memory word
  localparam int READ_SETTLE_CYCLES = 2;

endpackage : ext_memory_bus_pkg

/* File: bus_req_if.sv */
interface bus_req_if;
  logic        start;
  logic        is_write;
  logic        is_fetch;
  logic [19:0] addr;
  logic [1:0]  wait_count;
  logic [15:0] wdata;
  logic [7:0]  wstrobe;
  logic        busy;
  logic        done;
  logic [15:0] rdata;

  modport master (output start, is_write, is_fetch, addr, wait_count, wdata, wstrobe,
                  input busy, done, rdata);
  modport slave  (input start, is_write, is_fetch, addr, wait_count, wdata, wstrobe,
                  output busy, done, rdata);
endinterface : bus_req_if

/* File: bus_cycle_engine.sv */
module bus_cycle_engine (
  input  wire logic         clk,
  input  wire logic         srst,
  bus_req_if.slave          req,
  input  wire logic         bus_active,
  input  wire logic [15:0]  ad_in,
  output logic      [15:0]  ad_out,
  output logic      [15:0]  ad_oe_n,
  output logic      [3:0]   ahi_out,
  output logic      [7:0]   ctrl_out
);

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_WAIT, S_DATA, S_DONE} phase_t;

  phase_t      state_reg;
  logic [1:0]  wait_reg;
  logic        wr_reg;
  logic [19:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [7:0]  wstb_reg;
  logic [15:0] rdata_reg;
  logic [1:0]  settle;

  // Data phase extension: none for writes, the synchroniser depth for reads
  assign settle = wr_reg ? 2'h0 : 2'(ext_memory_bus_pkg::READ_SETTLE_CYCLES);

  // ----------------------------------------------------------------
  // Cycle sequencer: address, optional waits, data
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= S_IDLE;
      wait_reg  <= 2'h0;
      wr_reg    <= 1'b0;
      addr_reg  <= 20'h00000;
      wdata_reg <= 16'h0000;
      wstb_reg  <= ext_memory_bus_pkg::CTRL_IDLE;
    end
    else
    begin
      unique case (state_reg)
        S_IDLE:
        begin
          if (req.start)
          begin
            state_reg <= S_ADDR;
            wr_reg    <= req.is_write;
            addr_reg  <= req.addr;
            wdata_reg <= req.wdata;
            wstb_reg  <= req.wstrobe;
            // Fetches never stretch; only table cycles use the wait count
            wait_reg  <= req.is_fetch ? 2'h0 : req.wait_count;
          end
        end
        S_ADDR:
        begin
          if (wait_reg != 2'h0)
            state_reg <= S_WAIT;
          else
          begin
            state_reg <= S_DATA;
            wait_reg  <= settle;
          end
        end
        S_WAIT:
        begin
          if (wait_reg == 2'h1)
          begin
            state_reg <= S_DATA;
            wait_reg  <= settle;
          end
          else
            wait_reg <= wait_reg - 2'h1;
        end
        S_DATA:
        begin
          // Reads keep the output enable low until the pad data have settled
          if (wait_reg != 2'h0)
            wait_reg <= wait_reg - 2'h1;
          else
            state_reg <= S_DONE;
        end
        S_DONE:  state_reg <= S_IDLE;
      endcase
    end
  end

  // Read data taken on the last data cycle, once the synchroniser has caught up
  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_reg <= 16'h0000;
    else if (state_reg == S_DATA && !wr_reg && wait_reg == 2'h0)
      rdata_reg <= ad_in;
  end

  assign req.busy  = (state_reg != S_IDLE);
  assign req.done  = (state_reg == S_DONE);
  assign req.rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Pin drive; idle keeps the data lines released
  // ----------------------------------------------------------------
  always_comb
  begin
    ad_out   = 16'h0000;
    ad_oe_n  = 16'hFFFF;
    ahi_out  = 4'h0;
    ctrl_out = ext_memory_bus_pkg::CTRL_IDLE;
    if (bus_active && state_reg != S_IDLE && state_reg != S_DONE)
    begin
      ahi_out = addr_reg[19:16];
      ctrl_out[ext_memory_bus_pkg::CT_CE]  = 1'b0;
      ctrl_out[ext_memory_bus_pkg::CT_BA0] = wstb_reg[ext_memory_bus_pkg::CT_BA0];
      if (state_reg == S_ADDR)
      begin
        ad_out  = addr_reg[15:0];
        ad_oe_n = 16'h0000;
        ctrl_out[ext_memory_bus_pkg::CT_ALE] = 1'b1;
      end
      else if (wr_reg)
      begin
        // A word-write to an even address tristates the data phase
        ad_out  = wdata_reg;
        ad_oe_n = (wstb_reg == ext_memory_bus_pkg::CTRL_IDLE) ? 16'hFFFF : 16'h0000;
        ctrl_out[ext_memory_bus_pkg::CT_BA0] = wstb_reg[ext_memory_bus_pkg::CT_BA0];
        ctrl_out[ext_memory_bus_pkg::CT_LB]  = wstb_reg[ext_memory_bus_pkg::CT_LB];
        ctrl_out[ext_memory_bus_pkg::CT_UB]  = wstb_reg[ext_memory_bus_pkg::CT_UB];
        if (state_reg == S_DATA)
        begin
          ctrl_out[ext_memory_bus_pkg::CT_WRL] = wstb_reg[ext_memory_bus_pkg::CT_WRL];
          ctrl_out[ext_memory_bus_pkg::CT_WRH] = wstb_reg[ext_memory_bus_pkg::CT_WRH];
        end
      end
      else
      begin
        ctrl_out[ext_memory_bus_pkg::CT_OE] = 1'b0;
        ctrl_out[ext_memory_bus_pkg::CT_LB] = 1'b0;
        ctrl_out[ext_memory_bus_pkg::CT_UB] = 1'b0;
      end
    end
  end

endmodule : bus_cycle_engine

/* File: pin_mux.sv */
module pin_mux (
  input  wire logic         pins_are_bus,
  input  wire logic [26:0]  bus_out,
  input  wire logic [26:0]  bus_oe_n,
  input  wire logic [26:0]  port_out,
  input  wire logic [26:0]  port_oe_n,
  output logic      [26:0]  pin_out,
  output logic      [26:0]  pin_oe_n
);

  // ----------------------------------------------------------------
  // Per-pin selection between bus and port function
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < ext_memory_bus_pkg::PIN_COUNT; i++)
    begin : g_pin
      assign pin_out[i]  = pins_are_bus ? bus_out[i]  : port_out[i];
      assign pin_oe_n[i] = pins_are_bus ? bus_oe_n[i] : port_oe_n[i];
    end
  endgenerate

endmodule : pin_mux

/* File: ext_bus_monitor.sv */
module ext_bus_monitor (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire ext_memory_bus_pkg::prog_mode_t prog_mode,
  input wire logic        ext_req,
  input wire logic        ext_is_fetch,
  input wire logic        ext_busy,
  input wire logic        ext_done,
  input wire logic [26:0] port_out,
  input wire logic [26:0] port_oe_n,
  input wire logic        pins_are_bus,
  input wire logic [26:0] pin_out,
  input wire logic [26:0] pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------
  // Properties
  // --------------------------------
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (srst);

  // A fresh fetch request seen by an idle engine
  sequence fetch_go;
    $rose(ext_req) && !ext_busy && ext_is_fetch && prog_mode != 2'h3;
  endsequence

  a_full_ext_bus: assert property (prog_mode == 2'h0 |-> pins_are_bus)
    else $error("bus pins released in fully external mode");
  a_full_int_ports: assert property (prog_mode == 2'h3 |-> !pins_are_bus && !ext_busy)
    else $error("bus used in fully internal mode");
  a_port_passthru: assert property (!pins_are_bus |->
    pin_out == port_out && pin_oe_n == port_oe_n)
    else $error("port function not on the pins");
  a_ctrl_reads_zero: assert property (
    reg_rd && reg_addr == 4'h0 && prog_mode == 2'h3 |=> reg_rdata == 8'h00)
    else $error("control reads nonzero in internal mode");
  a_busy_on_bus: assert property (ext_busy |-> pins_are_bus)
    else $error("access without bus pins");
  // Address phase, output enable low in the first data cycle, completion three cycles later
  a_fetch_walk: assert property (fetch_go |=>
    pin_out[20] && !pin_out[25] ##1 !pin_out[21] ##3 ext_done)
    else $error("fetch cycle out of order");
  a_done_single: assert property (ext_done |=> !ext_done)
    else $error("done longer than one cycle");
  a_idle_levels: assert property (pins_are_bus && !ext_busy &&
    !$past(ext_busy) |-> pin_out[26:20] == 7'h6E && pin_oe_n[19:0] == 20'hFFFFF)
    else $error("idle bus levels wrong");

  c_fetch: cover property (fetch_go);
  c_ports_mixed: cover property (!pins_are_bus && prog_mode != 2'h3);
  c_done: cover property (ext_done && !ext_is_fetch);
endmodule // ext_bus_monitor

bind ext_memory_bus_control ext_bus_monitor i_mon (.clk, .srst, .reg_addr, .reg_rd,
  .reg_rdata, .prog_mode, .ext_req, .ext_is_fetch, .ext_busy, .ext_done, .port_out,
  .port_oe_n, .pins_are_bus, .pin_out, .pin_oe_n);

/* File: ext_mem_model.sv */
module ext_mem_model (
  input  wire logic        clk,
  input  wire logic [26:0] pin_out,
  input  wire logic [26:0] pin_oe_n,
  output logic      [15:0] mem_ad,
  output logic             mem_en,
  output logic      [19:0] wr_addr,
  output logic      [15:0] wr_data,
  output logic      [3:0]  wr_lines,
  output int               wr_count
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [19:0] addr_reg = 20'h00000;
  logic [1:0]  strobe_reg = 2'h3;
  logic        chip_sel;

  // Selected only while the enable line is really driven low
  assign chip_sel = !pin_out[25] && !pin_oe_n[25];

  // Latch all twenty address lines while ALE is high
  always_ff @(posedge clk)
    if (pin_out[20] && !pin_oe_n[20])
      addr_reg <= pin_out[19:0];

  // Whole word read; answers at once, a fast part
  assign mem_en = chip_sel && !pin_out[21] && !pin_oe_n[21];
  assign mem_ad = addr_reg[15:0] ^ 16'hC3A5;

  // Capture on the first edge of a strobe low phase, so long strobes count once
  always_ff @(posedge clk)
  begin
    strobe_reg <= pin_out[23:22];
    if (chip_sel && (strobe_reg & ~pin_out[23:22]) != 2'h0)
    begin
      wr_addr  <= addr_reg;
      wr_data  <= pin_out[15:0];
      wr_lines <= {pin_out[23:22], pin_out[24], pin_out[26]};
      wr_count <= wr_count + 1;
    end
  end
endmodule // ext_mem_model

/* File: tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  ext_memory_bus_pkg::prog_mode_t prog_mode = ext_memory_bus_pkg::MODE_MICROCONTROLLER;
  logic        exec_external = 1'b0;
  logic        ext_req = 1'b0;
  logic        ext_is_fetch = 1'b0;
  logic        ext_is_write = 1'b0;
  logic [20:0] table_pointer = 21'h000000;
  logic [7:0]  table_latch = 8'h00;
  logic        ext_busy;
  logic        ext_done;
  logic [15:0] ext_rdata;
  logic [26:0] port_out = 27'h2A5C3F1;
  logic [26:0] port_oe_n = 27'h1B0F0E5;
  logic        pins_are_bus;
  logic [26:0] pin_out;
  logic [26:0] pin_oe_n;
  logic [26:0] last_pin = 27'h0000000;
  logic [15:0] mem_ad;
  logic        mem_en;
  logic [19:0] wr_addr;
  logic [15:0] wr_data;
  logic [3:0]  wr_lines;
  int          wr_count;
  int          mismatches = 0;
  int          comparisons = 0;
  wire  [26:0] mem_mask = {11'h000, {16{mem_en}}};
  wire  [26:0] pin_in;

  // Undriven lines drift to the inverse of their last level
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & mem_mask & {11'h000, mem_ad})
                | (pin_oe_n & ~mem_mask & ~last_pin);

  always #2 clk = ~clk;

  always @(posedge clk)
    last_pin <= pin_in;

  ext_memory_bus_control i_dut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .prog_mode, .exec_external, .ext_req, .ext_is_fetch, .ext_is_write,
    .table_pointer, .table_latch, .ext_busy, .ext_done, .ext_rdata, .port_out,
    .port_oe_n, .pins_are_bus, .pin_in, .pin_out, .pin_oe_n);

  ext_mem_model i_mem (.clk, .pin_out, .pin_oe_n, .mem_ad, .mem_en, .wr_addr, .wr_data,
    .wr_lines, .wr_count);

  // --------------------------------
  // Tasks
  // --------------------------------
  function automatic logic [15:0] mem_word(input logic [20:0] p);
    return p[16:1] ^ 16'hC3A5;
  endfunction

  task automatic check_val(input logic [19:0] got, input logic [19:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic check_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check_val(20'(reg_rdata), 20'(exp));
  endtask

  task automatic check_pins(input logic exp);
    repeat (2) @(negedge clk);
    check_val(20'(pins_are_bus), 20'(exp));
  endtask

  // Request held until done; n counts falling edges up to the done cycle
  task automatic bus_op(input logic f, input logic w, input logic [20:0] p,
                        input logic [7:0] l, output logic [15:0] d, output int n);
    @(posedge clk);
    ext_is_fetch <= f;
    ext_is_write <= w;
    table_pointer <= p;
    table_latch <= l;
    ext_req <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (ext_done !== 1'b1 && n < 40);
    d = ext_rdata;
    @(posedge clk);
    ext_req <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("%0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // --------------------------------
  // Tests
  // --------------------------------
  initial
  begin : main
    logic [15:0] d;
    logic [7:0]  l;
    logic [7:0]  held;
    logic        b;
    int          n;
    int          c;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    reg_write(4'h0, 8'hFF);
    check_reg(4'h0, 8'h00);
    check_val(20'(pin_out == port_out && pin_oe_n == port_oe_n), 20'h00001);
    $display("test internal done");
    @(posedge clk);
    prog_mode <= ext_memory_bus_pkg::MODE_MICROPROCESSOR;
    reg_write(4'h0, 8'hFF);
    check_reg(4'h0, 8'hB3);
    check_reg(4'h5, 8'h00);
    check_pins(1'b1);
    bus_op(1'b1, 1'b0, 21'h012345, 8'h00, d, n);
    check_val(20'(d), 20'(mem_word(21'h012345)));
    check_val(20'(n), 20'h00006);
    // Every wait encoding, 11 meaning none
    for (int f = 0; f < 4; f++)
    begin
      reg_write(4'h0, 8'(f << 4));
      bus_op(1'b0, 1'b0, 21'h0ABCD0 + 21'(f), 8'h00, d, n);
      check_val(20'(n), 20'(9 - f));
      check_val(20'(d), 20'(mem_word(21'h0ABCD0 + 21'(f))));
    end
    $display("test reads done");
    // Even then odd pointer in byte write, byte select and word write
    held = 8'h00;
    for (int m = 0; m < 3; m++)
    begin
      reg_write(4'h0, 8'h30 | 8'(m));
      for (int k = 0; k < 2; k++)
      begin
        b = k[0];
        l = 8'h5A + 8'(2 * m + k);
        c = wr_count;
        bus_op(1'b0, 1'b1, 21'h000100 | 21'(k), l, d, n);
        if (m == 2 && k == 0)
          check_val(20'(wr_count - c), 20'h00000);
        else
        begin
          check_val(20'(wr_count - c), 20'h00001);
          check_val(wr_addr, 20'h00080);
          check_val(20'(wr_data), 20'(m == 2 ? {l, held} : {l, l}));
          check_val(20'(wr_lines[3:1]), 20'(m == 0 ? {~b, b, b} : {2'b01, b}));
          if (m > 0)
            check_val(20'(wr_lines[0]), 20'(m == 1 ? b : 1'b0));
        end
        held = l;
      end
    end
    $display("test writes done");
    for (int m = 1; m < 3; m++)
    begin
      @(posedge clk);
      prog_mode <= ext_memory_bus_pkg::prog_mode_t'(m);
      reg_write(4'h0, 8'h30);
      check_pins(1'b1);
      check_val(pin_oe_n[19:0], 20'hFFFFF);
      check_val(20'(pin_out[26:20]), 20'h0006E);
      reg_write(4'h0, 8'hB0);
      check_pins(1'b0);
      bus_op(1'b1, 1'b0, 21'h1F0002, 8'h00, d, n);
      check_val(20'(d), 20'(mem_word(21'h1F0002)));
      check_pins(1'b0);
      reg_write(4'h0, 8'h30);
      @(posedge clk);
      exec_external <= 1'b1;
      reg_write(4'h0, 8'hB0);
      check_pins(1'b1);
      check_reg(4'h1, 8'h01);
      @(posedge clk);
      exec_external <= 1'b0;
      check_pins(1'b0);
    end
    $display("test mixed done");
    report_and_stop();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule // tb
